// *** design/kpsm_map.vh ***
// Constants for the keypad setup menu controller
`ifndef KPSM_MAP_VH
`define KPSM_MAP_VH

// ****************************************
// Timing
// ****************************************
`define KPSM_CLK_HZ        32'd10000000
`define KPSM_HOLD_S        32'd5
`define KPSM_TIMEOUT_MIN   32'd4
`define KPSM_SEC_PER_MIN   32'd60

// ****************************************
// Setup item indexes
// ****************************************
`define KPSM_IT_CUST1      5'd1
`define KPSM_IT_CUST2      5'd2
`define KPSM_IT_DATE       5'd3
`define KPSM_IT_TIME       5'd4
`define KPSM_IT_YDATE      5'd5
`define KPSM_IT_MDATE      5'd6
`define KPSM_IT_FLOW       5'd7
`define KPSM_IT_UNIT       5'd8
`define KPSM_IT_ADDR1      5'd9
`define KPSM_IT_ADDR2      5'd10
`define KPSM_IT_ADDR3      5'd11
`define KPSM_IT_ADDR4      5'd12
`define KPSM_IT_HCL        5'd14
`define KPSM_IT_TOFS       5'd15
`define KPSM_IT_LOCK       5'd25
`define KPSM_IT_FIRST      5'd1
`define KPSM_IT_LAST       5'd25
`define KPSM_IT_YDATE2     5'd26
`define KPSM_IT_MDATE2     5'd27

// ****************************************
// Menu, display and limits
// ****************************************
`define KPSM_MENU_SETUP    2'd3
`define KPSM_SETUP_PREFIX  8'h30
`define KPSM_USER_FIRST    16'h1000
`define KPSM_MAX_SESS      6'd50
`define KPSM_ADDR_MAX      12'h250
`define KPSM_HC_TYPE       4'h6
`define KPSM_HC_MIN        20'h00200
`define KPSM_HC_MAX        20'h18000
`define KPSM_HC_OFF        20'h25000
`define KPSM_UNIT_KWH      4'h0
`define KPSM_UNIT_MWH      4'h1
`define KPSM_UNIT_MAX      4'h3
`define KPSM_RESET_VALUE   32'h00000000

`endif

// *** design/kpsm_key_press.v ***
// Key press classifier: short and long primary press, arrow edges
`include "kpsm_map.vh"

module kpsm_key_press #(
	parameter [31:0] HOLD_CYC = `KPSM_HOLD_S * `KPSM_CLK_HZ
) (
	// Clock and reset
	input  wire        clk,
	input  wire        nrst,
	// Raw key levels
	input  wire        pri,
	input  wire        left,
	input  wire        right,
	// Classified events, one cycle each
	output reg         short_press,
	output reg         long_press,
	output reg         left_press,
	output reg         right_press
);

	reg [31:0] hold_cnt;  // Cycles the primary key has been held
	reg        long_done; // Long press already reported
	reg        left_q;    // Previous arrow levels
	reg        right_q;

	// ****************************************
	// Hold timing
	// ****************************************
	// Long fires once at the hold time; short only if released before
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold_cnt    <= 32'h0;
			long_done   <= 1'b0;
			short_press <= 1'b0;
			long_press  <= 1'b0;
		end else begin
			short_press <= 1'b0;
			long_press  <= 1'b0;
			if (pri) begin
				if (!long_done) begin
					if (hold_cnt >= HOLD_CYC - 32'h1) begin
						long_press <= 1'b1;
						long_done  <= 1'b1;
					end else begin
						hold_cnt <= hold_cnt + 32'h1;
					end
				end
			end else begin
				// Release: short only when no long was reported
				short_press <= (hold_cnt != 32'h0) && !long_done;
				hold_cnt    <= 32'h0;
				long_done   <= 1'b0;
			end
		end
	end

	// ****************************************
	// Arrow edges
	// ****************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			left_q      <= 1'b0;
			right_q     <= 1'b0;
			left_press  <= 1'b0;
			right_press <= 1'b0;
		end else begin
			left_q      <= left;
			right_q     <= right;
			left_press  <= left && !left_q;
			right_press <= right && !right_q;
		end
	end

endmodule // kpsm_key_press

// *** design/kpsm_setup_menu.v ***
// Keypad setup menu controller top level
// Operation
// - Hold 5 s opens menu; short press on loop 3 enters setup
// - Setup index always shown as four digits
// - Arrows step to neighbouring reading while browsing
// - Short press edits, leftmost digit flashing
// - Short press in edit steps flashing digit
// - Arrows move edit position freely left/right
// - Hold in edit saves an in-range value, shows OK, new value
// - Disabled item shows OFF; press only frames
// - Setup items form fixed list 3-001 to 3-025
// - Heat/cool limit editable only on type 6
// - Customer number is two 8-digit halves
// - Yearly date MM.DD; second yearly defaults off
// - Second monthly date defaults off, zero day
// - Flow position selects inlet/outlet, indicator follows
// - Unit kWh/MWh/GJ/Gcal; resolution from factory code
// - kWh not permitted stores MWh instead
// - Slot primary addresses limited 0 to 250
// - Sensor offset shows OFF when country disables
// - Four minutes idle returns to user loop
// - Setup access locked after 50 sessions
`include "kpsm_map.vh"

module kpsm_setup_menu #(
	parameter [31:0] HOLD_CYC    = `KPSM_HOLD_S * `KPSM_CLK_HZ,
	parameter [31:0] TIMEOUT_CYC = `KPSM_TIMEOUT_MIN * `KPSM_SEC_PER_MIN
	                               * `KPSM_CLK_HZ
) (
	// Clock and reset
	input  wire        CLK,
	input  wire        NRST,
	// Front keys
	input  wire        PRI_KEY,
	input  wire        LEFT_KEY,
	input  wire        RIGHT_KEY,
	// Factory configuration
	input  wire [3:0]  METER_TYPE,
	input  wire        KWH_ALLOWED,
	input  wire        TEMP_OFS_DIS,
	input  wire [24:0] FUNC_DIS,
	// Display
	output reg  [15:0] DISP_INDEX,
	output reg  [31:0] DISP_VALUE,
	output reg  [3:0]  DISP_DIGITS,
	output reg  [2:0]  CURSOR,
	output reg         FLASH,
	output reg         SHOW_OFF,
	output reg         SHOW_FRAMES,
	output reg         SHOW_OK,
	output reg         IN_SETUP,
	// Stored parameters
	output reg  [63:0] CUSTOMER_ID,
	output reg         FLOW_INLET,
	output reg  [1:0]  ENERGY_UNIT,
	output reg  [47:0] SLOT_ADDR,
	output reg         DUAL_YEARLY,
	output reg         DUAL_MONTHLY,
	output reg         SETUP_LOCK,
	output reg  [5:0]  SESSIONS
);

	// ****************************************
	// States
	// ****************************************
	localparam [2:0] ST_USER   = 3'd0; // User display loop
	localparam [2:0] ST_MENU   = 3'd1; // Loop selection
	localparam [2:0] ST_BROWSE = 3'd2; // Setup readings
	localparam [2:0] ST_EDIT   = 3'd3; // Digit editing
	localparam [2:0] ST_OK     = 3'd4; // Save confirmed

	reg  [2:0]  state;       // Control state
	reg  [1:0]  menu;        // Selected loop in menu
	reg  [4:0]  item;        // Current setup reading
	reg  [2:0]  cur;         // Edit position from the left
	reg  [31:0] edit_val;    // Working copy while editing
	reg  [31:0] idle_cnt;    // Cycles since last key activity
	reg         locked;      // Lock item used
	reg  [5:0]  sess;        // Sessions used
	reg  [31:0] store [1:27]; // Parameter values, BCD

	wire        short_press; // Key events
	wire        long_press;
	wire        left_press;
	wire        right_press;
	wire [3:0]  ndig;        // Digits of current item
	wire [3:0]  pos;         // Nibble under the cursor
	wire [31:0] stepped;     // Edit value with digit stepped
	wire        item_off;    // Current item disabled
	wire        can_enter;   // Setup access allowed
	wire        any_key;     // Activity restarts the timeout
	integer     i;

	// ****************************************
	// Key classifier
	// ****************************************
	kpsm_key_press #(
		.HOLD_CYC    (HOLD_CYC)
	) u_keys (
		.clk         (CLK),
		.nrst        (NRST),
		.pri         (PRI_KEY),
		.left        (LEFT_KEY),
		.right       (RIGHT_KEY),
		.short_press (short_press),
		.long_press  (long_press),
		.left_press  (left_press),
		.right_press (right_press)
	);

	// ****************************************
	// Item properties
	// ****************************************
	// Digit count per item; lock item has none
	function [3:0] digits_of;
		input [4:0] it;
		begin
			case (it)
				`KPSM_IT_CUST1, `KPSM_IT_CUST2: digits_of = 4'd8;
				`KPSM_IT_DATE, `KPSM_IT_TIME:   digits_of = 4'd6;
				`KPSM_IT_YDATE:                 digits_of = 4'd4;
				`KPSM_IT_MDATE, `KPSM_IT_TOFS:  digits_of = 4'd2;
				`KPSM_IT_FLOW, `KPSM_IT_UNIT:   digits_of = 4'd1;
				`KPSM_IT_HCL:                   digits_of = 4'd5;
				`KPSM_IT_LOCK:                  digits_of = 4'd0;
				default: begin
					// Slot addresses take three digits
					if (it >= `KPSM_IT_ADDR1 && it <= `KPSM_IT_ADDR4)
						digits_of = 4'd3;
					else
						digits_of = 4'd8;
				end
			endcase
		end
	endfunction

	// Range check on the save gesture; BCD orders like decimal
	function in_range;
		input [4:0]  it;
		input [31:0] v;
		begin
			case (it)
				`KPSM_IT_DATE: in_range = v[15:8] >= 8'h01
					&& v[15:8] <= 8'h12 && v[7:0] >= 8'h01
					&& v[7:0] <= 8'h31;
				`KPSM_IT_TIME: in_range = v[23:16] < 8'h24
					&& v[15:8] < 8'h60 && v[7:0] < 8'h60;
				`KPSM_IT_YDATE: in_range = v[15:8] >= 8'h01
					&& v[15:8] <= 8'h12 && v[7:0] >= 8'h01
					&& v[7:0] <= 8'h31;
				`KPSM_IT_MDATE: in_range = v[7:0] >= 8'h01
					&& v[7:0] <= 8'h31;
				`KPSM_IT_FLOW: in_range = v[3:0] <= 4'h1;
				`KPSM_IT_UNIT: in_range = v[3:0] <= `KPSM_UNIT_MAX;
				`KPSM_IT_HCL: in_range = (v[19:0] >= `KPSM_HC_MIN
					&& v[19:0] <= `KPSM_HC_MAX)
					|| v[19:0] == `KPSM_HC_OFF;
				default: begin
					// Module slots 0 to 250, others unchecked
					if (it >= `KPSM_IT_ADDR1 && it <= `KPSM_IT_ADDR4)
						in_range = v[11:0] <= `KPSM_ADDR_MAX;
					else
						in_range = 1'b1;
				end
			endcase
		end
	endfunction

	// Two-digit BCD of the item number
	function [7:0] bcd_of;
		input [4:0] it;
		begin
			if (it >= 5'd20)
				bcd_of = {4'h2, it[3:0] - 4'h4};
			else if (it >= 5'd10)
				bcd_of = {4'h1, it[3:0] - 4'ha};
			else
				bcd_of = {4'h0, it[3:0]};
		end
	endfunction

	assign ndig = digits_of(item);
	// Cursor counts from the left, nibbles from the right
	assign pos = ndig - 4'd1 - {1'b0, cur};
	// Factory disables, meter type and country code gate items
	assign item_off = FUNC_DIS[item - 5'd1]
		|| (item == `KPSM_IT_HCL && METER_TYPE != `KPSM_HC_TYPE)
		|| (item == `KPSM_IT_TOFS && TEMP_OFS_DIS);
	assign can_enter = !locked && sess < `KPSM_MAX_SESS;
	assign any_key = PRI_KEY || LEFT_KEY || RIGHT_KEY;

	// ****************************************
	// Digit stepping, one nibble per digit
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_step
			wire [3:0] nib = edit_val[4*g+3:4*g];
			// Digits wrap 9 back to 0
			assign stepped[4*g+3:4*g] = (pos == g) ?
				((nib >= 4'h9) ? 4'h0 : nib + 4'h1) : nib;
		end
	endgenerate

	// ****************************************
	// Control state machine
	// ****************************************
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state    <= ST_USER;
			menu     <= 2'd0;
			item     <= `KPSM_IT_FIRST;
			cur      <= 3'd0;
			edit_val <= 32'h0;
			idle_cnt <= 32'h0;
			locked   <= 1'b0;
			sess     <= 6'd0;
			// Second target dates start off as zeros
			for (i = 1; i <= 27; i = i + 1)
				store[i] <= `KPSM_RESET_VALUE;
		end else begin
			// Idle timer runs outside the user loop only
			if (state == ST_USER || any_key)
				idle_cnt <= 32'h0;
			else
				idle_cnt <= idle_cnt + 32'h1;
			if (state != ST_USER && idle_cnt >= TIMEOUT_CYC - 32'h1) begin
				state <= ST_USER;
			end else begin
				case (state)
					ST_USER: begin
						// Long hold opens the loop selection
						if (long_press) begin
							state <= ST_MENU;
							menu  <= 2'd0;
						end
					end
					ST_MENU: begin
						if (left_press)
							menu <= menu - 2'd1;
						else if (right_press)
							menu <= menu + 2'd1;
						else if (short_press) begin
							// Only the setup loop is handled here
							if (menu == `KPSM_MENU_SETUP && can_enter) begin
								state <= ST_BROWSE;
								item  <= `KPSM_IT_FIRST;
								sess  <= sess + 6'd1;
							end else begin
								state <= ST_USER;
							end
						end
					end
					ST_BROWSE: begin
						// Fixed ordered list, wrapping at both ends
						if (left_press)
							item <= (item == `KPSM_IT_FIRST) ?
								`KPSM_IT_LAST : item - 5'd1;
						else if (right_press)
							item <= (item == `KPSM_IT_LAST) ?
								`KPSM_IT_FIRST : item + 5'd1;
						else if (long_press && !item_off) begin
							// Hold on lock item closes setup for good
							if (item == `KPSM_IT_LOCK)
								locked <= 1'b1;
							state <= ST_USER;
						end else if (short_press && !item_off
							&& item != `KPSM_IT_LOCK) begin
							state    <= ST_EDIT;
							cur      <= 3'd0;
							edit_val <= store[item];
						end
					end
					ST_EDIT: begin
						// Free movement, wrapping over the item width
						if (left_press)
							cur <= (cur == 3'd0) ?
								ndig[2:0] - 3'd1 : cur - 3'd1;
						else if (right_press)
							cur <= ({1'b0, cur} >= ndig - 4'd1) ?
								3'd0 : cur + 3'd1;
						else if (short_press)
							edit_val <= stepped;
						else if (long_press) begin
							if (in_range(item, edit_val)) begin
								// kWh falls back to MWh if resolution forbids
								if (item == `KPSM_IT_UNIT
									&& edit_val[3:0] == `KPSM_UNIT_KWH
									&& !KWH_ALLOWED)
									store[item] <= {28'h0, `KPSM_UNIT_MWH};
								else
									store[item] <= edit_val;
								state <= ST_OK;
							end else begin
								state <= ST_BROWSE;
							end
						end
					end
					ST_OK: begin
						// OK stays until the key is let go
						if (!PRI_KEY)
							state <= ST_BROWSE;
					end
					default: state <= ST_USER;
				endcase
			end
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	// One cycle behind the state; keeps every output on a flop
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			DISP_INDEX   <= `KPSM_USER_FIRST;
			DISP_VALUE   <= 32'h0;
			DISP_DIGITS  <= 4'h0;
			CURSOR       <= 3'd0;
			FLASH        <= 1'b0;
			SHOW_OFF     <= 1'b0;
			SHOW_FRAMES  <= 1'b0;
			SHOW_OK      <= 1'b0;
			IN_SETUP     <= 1'b0;
			CUSTOMER_ID  <= 64'h0;
			FLOW_INLET   <= 1'b0;
			ENERGY_UNIT  <= 2'd0;
			SLOT_ADDR    <= 48'h0;
			DUAL_YEARLY  <= 1'b0;
			DUAL_MONTHLY <= 1'b0;
			SETUP_LOCK   <= 1'b0;
			SESSIONS     <= 6'd0;
		end else begin
			IN_SETUP <= state == ST_BROWSE || state == ST_EDIT
				|| state == ST_OK;
			// Setup index: prefix 3 and item number, four digits
			if (state == ST_USER)
				DISP_INDEX <= `KPSM_USER_FIRST;
			else if (state == ST_MENU)
				DISP_INDEX <= {2'b00, menu, 12'h000};
			else
				DISP_INDEX <= {`KPSM_SETUP_PREFIX, bcd_of(item)};
			// Editing shows the working copy, else the stored value
			DISP_VALUE  <= (state == ST_EDIT) ? edit_val : store[item];
			DISP_DIGITS <= ndig;
			CURSOR      <= cur;
			FLASH       <= state == ST_EDIT;
			SHOW_OFF    <= state == ST_BROWSE && item_off;
			// Frames only while the key is held on an OFF item
			SHOW_FRAMES <= state == ST_BROWSE && item_off && PRI_KEY;
			SHOW_OK     <= state == ST_OK;
			CUSTOMER_ID <= {store[`KPSM_IT_CUST1], store[`KPSM_IT_CUST2]};
			FLOW_INLET  <= store[`KPSM_IT_FLOW][0];
			// Resolution is not touched here; it follows the factory code
			ENERGY_UNIT <= store[`KPSM_IT_UNIT][1:0];
			SLOT_ADDR   <= {store[`KPSM_IT_ADDR4][11:0],
				store[`KPSM_IT_ADDR3][11:0], store[`KPSM_IT_ADDR2][11:0],
				store[`KPSM_IT_ADDR1][11:0]};
			DUAL_YEARLY  <= store[`KPSM_IT_YDATE2][15:0] != 16'h0;
			DUAL_MONTHLY <= store[`KPSM_IT_MDATE2][7:0] != 8'h0;
			SETUP_LOCK   <= !can_enter;
			SESSIONS     <= sess;
		end
	end

endmodule // kpsm_setup_menu

// *** dv/kpsm_setup_menu_properties.sv ***
// Checker for the keypad setup menu top level
module kpsm_setup_menu_props (
	// Clock and reset
	input wire        CLK,
	input wire        NRST,
	// Keys and configuration
	input wire        PRI_KEY,
	input wire [3:0]  METER_TYPE,
	input wire        KWH_ALLOWED,
	// Display
	input wire [15:0] DISP_INDEX,
	input wire        FLASH,
	input wire        SHOW_FRAMES,
	input wire        SHOW_OK,
	input wire        IN_SETUP,
	// Stored parameters
	input wire [1:0]  ENERGY_UNIT,
	input wire [47:0] SLOT_ADDR,
	input wire        DUAL_YEARLY,
	input wire        DUAL_MONTHLY,
	input wire        SETUP_LOCK,
	input wire [5:0]  SESSIONS
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// Index is 30NN with NN a BCD item number
	a_setup_index_form: assert property (IN_SETUP |->
		DISP_INDEX[15:8] == 8'h30 && DISP_INDEX[7:0] >= 8'h01 &&
		DISP_INDEX[7:0] <= 8'h25 && DISP_INDEX[3:0] <= 4'h9)
		else $error("setup index malformed");
	a_flash_in_setup: assert property (FLASH |-> IN_SETUP)
		else $error("flash outside setup");
	a_hcl_no_edit: assert property (
		DISP_INDEX == 16'h3014 && METER_TYPE != 4'h6 |-> !FLASH)
		else $error("limit edited on wrong type");
	a_frames_no_edit: assert property (SHOW_FRAMES |-> !FLASH)
		else $error("frames during edit");
	a_ok_on_release: assert property (
		SHOW_OK && !PRI_KEY |-> ##[0:3] !SHOW_OK)
		else $error("ok held after release");
	a_addr_limit: assert property (SLOT_ADDR[11:0] <= 12'h250 &&
		SLOT_ADDR[23:12] <= 12'h250 && SLOT_ADDR[35:24] <= 12'h250 &&
		SLOT_ADDR[47:36] <= 12'h250)
		else $error("slot address above limit");
	a_unit_fallback: assert property (
		$changed(ENERGY_UNIT) && !KWH_ALLOWED |-> ENERGY_UNIT != 2'd0)
		else $error("kwh stored when not allowed");
	a_dual_default: assert property (!DUAL_YEARLY && !DUAL_MONTHLY)
		else $error("second target date active");
	a_session_cap: assert property (SESSIONS <= 6'd50)
		else $error("session count above cap");
	a_session_step: assert property (
		$changed(SESSIONS) |-> SESSIONS == $past(SESSIONS) + 6'd1)
		else $error("session count jumped");
	a_lock_sticky: assert property (SETUP_LOCK |=> SETUP_LOCK)
		else $error("lock released");
	a_lock_no_entry: assert property (
		SETUP_LOCK && !IN_SETUP |=> !IN_SETUP)
		else $error("setup entered while locked");

	// Main scenarios reached
	c_edit: cover property ($rose(FLASH));
	c_ok: cover property ($rose(SHOW_OK));
	c_frames: cover property ($rose(SHOW_FRAMES));
	c_lock: cover property ($rose(SETUP_LOCK));
endmodule // kpsm_setup_menu_props

bind kpsm_setup_menu kpsm_setup_menu_props i_kpsm_setup_menu_props (
	.CLK(CLK), .NRST(NRST), .PRI_KEY(PRI_KEY), .METER_TYPE(METER_TYPE),
	.KWH_ALLOWED(KWH_ALLOWED), .DISP_INDEX(DISP_INDEX), .FLASH(FLASH),
	.SHOW_FRAMES(SHOW_FRAMES), .SHOW_OK(SHOW_OK), .IN_SETUP(IN_SETUP),
	.ENERGY_UNIT(ENERGY_UNIT), .SLOT_ADDR(SLOT_ADDR),
	.DUAL_YEARLY(DUAL_YEARLY), .DUAL_MONTHLY(DUAL_MONTHLY),
	.SETUP_LOCK(SETUP_LOCK), .SESSIONS(SESSIONS));

// *** dv/kpsm_operator.sv ***
// Operator model pressing the front keys
module kpsm_operator (
	// Clock
	input  wire  clk,
	// Key levels, high while pressed
	output logic pri,
	output logic left,
	output logic right
);
	timeunit 1ns;
	timeprecision 1ns;
	// Keys released at time zero
	initial begin
		pri = 1'b0;
		left = 1'b0;
		right = 1'b0;
	end
	// Let the classifier settle between gestures
	task gap();
		repeat (5) @(posedge clk);
	endtask
	// Primary key down for n cycles, key stays down
	task hold(input int n);
		@(posedge clk) #1 pri = 1'b1;
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Release primary key
	task release_pri();
		@(posedge clk) #1 pri = 1'b0;
		gap();
		#1;
	endtask
	// Brief press then release
	task press(input int n);
		hold(n);
		release_pri();
	endtask
	// Arrow tapped n times, right when r is set
	task arrow(input bit r, input int n);
		repeat (n) begin
			@(posedge clk) #1 if (r) right = 1'b1; else left = 1'b1;
			@(posedge clk) #1 right = 1'b0;
			left = 1'b0;
			gap();
			#1;
		end
	endtask
endmodule // kpsm_operator

// *** dv/test_keypad_setup_menu.sv ***
// Testbench for the keypad setup menu controller
module test_keypad_setup_menu;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Signals
	// ****************************************
	localparam int HOLD = 20;           // Shortened 5 s hold
	localparam int TMO  = 500;          // Shortened 4 min timeout
	logic        clk, nrst, pri, lft, rgt, kwh_ok, tofs_dis;
	logic [3:0]  mtype, digits;
	logic [24:0] fdis;
	logic [15:0] idx;
	logic [31:0] val;
	logic [2:0]  cursor;
	logic        flash, off, frames, ok, in_setup, inlet, dy, dm, lock;
	logic [63:0] cust;
	logic [1:0]  unit;
	logic [47:0] slot;
	logic [5:0]  sess;
	int          mismatches = 0;
	int          tests_run = 0;

	kpsm_operator i_kpsm_operator (.clk(clk), .pri(pri), .left(lft),
		.right(rgt));
	kpsm_setup_menu #(.HOLD_CYC(HOLD), .TIMEOUT_CYC(TMO)) i_kpsm_setup_menu (
		.CLK(clk), .NRST(nrst), .PRI_KEY(pri), .LEFT_KEY(lft),
		.RIGHT_KEY(rgt), .METER_TYPE(mtype), .KWH_ALLOWED(kwh_ok),
		.TEMP_OFS_DIS(tofs_dis), .FUNC_DIS(fdis), .DISP_INDEX(idx),
		.DISP_VALUE(val), .DISP_DIGITS(digits), .CURSOR(cursor),
		.FLASH(flash), .SHOW_OFF(off), .SHOW_FRAMES(frames), .SHOW_OK(ok),
		.IN_SETUP(in_setup), .CUSTOMER_ID(cust), .FLOW_INLET(inlet),
		.ENERGY_UNIT(unit), .SLOT_ADDR(slot), .DUAL_YEARLY(dy),
		.DUAL_MONTHLY(dm), .SETUP_LOCK(lock), .SESSIONS(sess));

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Compare with four-state equality
	task cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Short presses stepping a digit
	task steps(input int n);
		repeat (n) i_kpsm_operator.press(2);
	endtask
	// Save gesture; OK expected or not while held
	task save(input logic exp_ok);
		i_kpsm_operator.hold(HOLD + 4);
		cmp("ok", exp_ok, ok);
		i_kpsm_operator.release_pri();
	endtask
	// Long hold opens the menu, loop 3 then short press
	task enter();
		i_kpsm_operator.hold(HOLD + 4);
		i_kpsm_operator.release_pri();
		i_kpsm_operator.arrow(1, 3);
		steps(1);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_enter();
		i_kpsm_operator.hold(HOLD + 4);
		i_kpsm_operator.release_pri();
		cmp("index", 16'h0000, idx);
		i_kpsm_operator.arrow(1, 3);
		cmp("index", 16'h3000, idx);
		steps(1);
		cmp("index", 16'h3001, idx);
		cmp("sessions", 6'd1, sess);
		cmp("digits", 4'd8, digits);
		cmp("dual", 2'b00, {dy, dm});
		$display("test enter done");
	endtask
	task t_browse();
		i_kpsm_operator.arrow(1, 1);
		cmp("index", 16'h3002, idx);
		i_kpsm_operator.arrow(0, 2);
		cmp("index", 16'h3025, idx);
		i_kpsm_operator.arrow(1, 1);
		cmp("index", 16'h3001, idx);
		$display("test browse done");
	endtask
	task t_cust();
		steps(1);
		cmp("flash", 1'b1, flash);
		cmp("cursor", 3'd0, cursor);
		steps(1);
		cmp("value", 32'h10000000, val);
		i_kpsm_operator.arrow(1, 1);
		steps(1);
		cmp("value", 32'h11000000, val);
		i_kpsm_operator.arrow(0, 2);
		cmp("cursor", 3'd7, cursor);
		steps(1);
		save(1'b1);
		cmp("customer", 64'h11000001_00000000, cust);
		cmp("value", 32'h11000001, val);
		$display("test customer done");
	endtask
	task t_flow_unit();
		i_kpsm_operator.arrow(1, 6);
		steps(2);
		save(1'b1);
		cmp("inlet", 1'b1, inlet);
		i_kpsm_operator.arrow(1, 1);
		steps(3);
		save(1'b1);
		cmp("unit", 2'd2, unit);
		steps(9);
		save(1'b1);
		cmp("unit", 2'd1, unit);
		$display("test flow unit done");
	endtask
	task t_addr();
		i_kpsm_operator.arrow(1, 1);
		steps(4);
		save(1'b0);
		cmp("slot", 48'h0, slot);
		cmp("value", 32'h0, val);
		steps(3);
		i_kpsm_operator.arrow(1, 1);
		steps(5);
		save(1'b1);
		cmp("slot", 48'h250, slot);
		$display("test address done");
	endtask
	task t_off();
		i_kpsm_operator.arrow(1, 5);
		cmp("off", 1'b1, off);
		i_kpsm_operator.hold(4);
		cmp("frames", 1'b1, frames);
		i_kpsm_operator.release_pri();
		cmp("flash", 1'b0, flash);
		i_kpsm_operator.arrow(1, 1);
		cmp("off", 1'b1, off);
		$display("test off done");
	endtask
	// Other factory settings: type 6, kWh allowed, item 2 disabled
	task t_config();
		fdis = 25'h2;
		mtype = 4'h6;
		kwh_ok = 1'b1;
		i_kpsm_operator.arrow(0, 1);
		cmp("off", 1'b0, off);
		steps(1);
		cmp("flash", 1'b1, flash);
		save(1'b0);
		i_kpsm_operator.arrow(0, 6);
		steps(10);
		save(1'b1);
		cmp("unit", 2'd0, unit);
		i_kpsm_operator.arrow(0, 6);
		cmp("off", 1'b1, off);
		$display("test config done");
	endtask
	task t_timeout();
		int n;
		n = 0;
		while (idx !== 16'h1000 && n < TMO + 50) begin
			@(posedge clk) #1;
			n++;
		end
		if (n >= TMO + 50) begin
			cmp("timeout", 1'b1, 1'b0);
			complete_run();
		end
		cmp("in_setup", 1'b0, in_setup);
		$display("test timeout done");
	endtask
	task t_lock();
		repeat (49) begin
			enter();
			save(1'b0);
		end
		cmp("sessions", 6'd50, sess);
		cmp("lock", 1'b1, lock);
		enter();
		cmp("index", 16'h1000, idx);
		cmp("in_setup", 1'b0, in_setup);
		$display("test lock done");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		kwh_ok = 1'b0;
		tofs_dis = 1'b1;
		mtype = 4'h1;
		fdis = 25'h0;
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		@(posedge clk) #1;
		cmp("index", 16'h1000, idx);
		t_enter();
		t_browse();
		t_cust();
		t_flow_unit();
		t_addr();
		t_off();
		t_config();
		t_timeout();
		t_lock();
		complete_run();
	end
endmodule // test_keypad_setup_menu
